//--- inc/burst_fill_pkg.sv
// Shared constants and types for the burst fill sequencer and its processor end.
package burst_fill_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int LOW_W = 2;
   localparam int BURST_WORDS = 4;
   localparam int FIRST_WAIT = 3;
   localparam logic [1:0] LOW_STEP = 2'h1;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   localparam logic [1:0] WAIT_INIT = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_BURST} seq_state_t;
   typedef enum logic [1:0] {CPU_IDLE, CPU_WAIT, CPU_RECV} cpu_state_t;
endpackage

//--- inc/burst_fill_if.sv
// Link between the processor end and the burst fill sequencer.
`timescale 1ns/100ps
`default_nettype none
interface burst_fill_if;
   import burst_fill_pkg::*;
   logic cache_burst_request;
   logic cache_burst_acknowledge;
   logic [ADDR_W-1:0] cpu_addr;
   logic data_valid;
   logic [DATA_W-1:0] data;
   modport cpu (output cache_burst_request, output cpu_addr, input cache_burst_acknowledge,
      input data_valid, input data);
   modport seq (input cache_burst_request, input cpu_addr, output cache_burst_acknowledge,
      output data_valid, output data);
endinterface
`default_nettype wire

//--- core/burst_fill_address_sequencer.sv
// Sequencer that bursts four long words from a synchronous RAM bank to the processor.
`timescale 1ns/100ps
`default_nettype none
// Two-bit burst counter with a parallel load; the load wins over the count.
module burst_low_counter
   import burst_fill_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Load and count controls
   input wire logic i_counter_parallel_load,
   input wire logic i_count_en,
   input wire logic [LOW_W-1:0] i_load_value,
   // Low address bits
   output logic [LOW_W-1:0] o_low
);
   logic [LOW_W-1:0] low_q, low_d;

   // The carry out of the low bits is dropped, so a burst wraps inside its block.
   function automatic logic [LOW_W-1:0] next_low(input logic [LOW_W-1:0] cur);
      return LOW_W'(cur + LOW_STEP);
   endfunction

   always_comb begin
      low_d = low_q;
      if (i_counter_parallel_load) begin
         low_d = i_load_value;
      end else if (i_count_en) begin
         low_d = next_low(low_q);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         low_q <= '0;
      end else begin
         low_q <= low_d;
      end
   end

   assign o_low = low_q;
endmodule // burst_low_counter

module burst_fill_address_sequencer
   import burst_fill_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Processor link
   burst_fill_if.seq bus,
   // Write port from the cache controller
   input wire logic i_write_en,
   input wire logic [ADDR_W-1:0] i_write_addr,
   input wire logic [DATA_W-1:0] i_write_data,
   // Status
   output logic o_busy
);
   // The inverted-phase clock is modelled as this single clock edge, so the
   // counter and the array stay in one domain.
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   seq_state_t state_q, state_d;
   logic [LOW_W-1:0] low_addr;
   logic count_en;
   logic [1:0] wait_q, wait_d;
   logic [1:0] beat_q, beat_d;
   logic counter_parallel_load;
   logic ack_q, ack_d;
   logic valid_q, valid_d;
   logic busy_q, busy_d;
   logic [DATA_W-1:0] data_q;
   logic [ADDR_W-1:0] ram_addr;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [DATA_W-1:0] wr_data_q;
   logic wr_en_q;
   logic wr_en_d;
   logic [ADDR_W-1:0] wr_addr_d;
   logic [DATA_W-1:0] wr_data_d;
   logic [DATA_W-1:0] rd_data_d;

   // The counter stands in for the discrete counter beside the RAM bank.
   burst_low_counter i_burst_low_counter (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_counter_parallel_load(counter_parallel_load),
      .i_count_en(count_en),
      .i_load_value(bus.cpu_addr[LOW_W-1:0]),
      .o_low(low_addr)
   );

   // Upper bits straight from the processor, low bits from the counter.
   assign ram_addr = {bus.cpu_addr[ADDR_W-1:LOW_W], low_addr};

   always_comb begin
      state_d = state_q;
      wait_d = wait_q;
      beat_d = beat_q;
      ack_d = 1'b0;
      valid_d = 1'b0;
      busy_d = busy_q;
      counter_parallel_load = 1'b0;
      count_en = 1'b0;
      case (state_q)
         ST_IDLE: begin
            // A write still in the capture stage holds off a new burst, so a fill never meets a half-done write.
            if (bus.cache_burst_request && !wr_en_q) begin
               counter_parallel_load = 1'b1;
               ack_d = 1'b1;
               wait_d = WAIT_INIT;
               beat_d = 2'h0;
               busy_d = 1'b1;
               state_d = ST_FIRST;
            end
         end
         ST_FIRST: begin
            // Load is already dropped; the loaded address is being read.
            if (wait_q == 2'h1) begin
               valid_d = 1'b1;
               count_en = 1'b1;
               state_d = ST_BURST;
            end else begin
               wait_d = wait_q - 2'h1;
            end
         end
         ST_BURST: begin
            valid_d = 1'b1;
            beat_d = beat_q + 2'h1;
            count_en = 1'b1;
            if (beat_q == BEAT_LAST - 2'h1) begin
               state_d = ST_IDLE;
               busy_d = 1'b0;
            end
         end
         default: begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_IDLE;
         wait_q <= 2'h0;
         beat_q <= 2'h0;
         ack_q <= 1'b0;
         valid_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_q <= wait_d;
         beat_q <= beat_d;
         ack_q <= ack_d;
         valid_q <= valid_d;
         busy_q <= busy_d;
      end
   end

   // Write inputs are captured on the edge, so no write pulse is shaped.
   always_comb begin
      wr_en_d = i_write_en;
      wr_addr_d = i_write_addr;
      wr_data_d = i_write_data;
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_en_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_en_q <= wr_en_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
      end
   end

   // The array registers its read word on the edge; storage has no reset.
   always_comb begin
      rd_data_d = mem[ram_addr];
   end

   always_ff @(posedge i_sys_clk) begin
      if (wr_en_q) begin
         mem[wr_addr_q] <= wr_data_q;
      end
      data_q <= rd_data_d;
   end

   assign bus.cache_burst_acknowledge = ack_q;
   assign bus.data_valid = valid_q;
   assign bus.data = data_q;
   assign o_busy = busy_q;
endmodule // burst_fill_address_sequencer
`default_nettype wire

//--- core/burst_fill_cpu_end.sv
// Processor end that requests a four word burst fill and collects the words.
`timescale 1ns/100ps
`default_nettype none
module burst_fill_cpu_end
   import burst_fill_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Link to the sequencer
   burst_fill_if.cpu bus,
   // Fill request from the cache
   input wire logic i_fill_req,
   input wire logic [ADDR_W-1:0] i_fill_addr,
   // Delivered words
   output logic o_word_valid,
   output logic [DATA_W-1:0] o_word,
   output logic [1:0] o_word_index,
   output logic o_fill_done
);
   cpu_state_t state_q, state_d;
   logic req_q, req_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [1:0] cnt_q, cnt_d;
   logic done_d, wv_d;
   logic done_q, wv_q;
   logic [DATA_W-1:0] word_q, word_d;
   logic [1:0] idx_q, idx_d;

   always_comb begin
      state_d = state_q;
      req_d = req_q;
      addr_d = addr_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      wv_d = 1'b0;
      word_d = word_q;
      idx_d = idx_q;
      case (state_q)
         CPU_IDLE: begin
            if (i_fill_req) begin
               req_d = 1'b1;
               addr_d = i_fill_addr;
               cnt_d = 2'h0;
               state_d = CPU_WAIT;
            end
         end
         CPU_WAIT: begin
            if (bus.cache_burst_acknowledge) begin
               req_d = 1'b0;
               state_d = CPU_RECV;
            end
         end
         CPU_RECV: begin
            if (bus.data_valid) begin
               wv_d = 1'b1;
               word_d = bus.data;
               idx_d = cnt_q;
               cnt_d = cnt_q + 2'h1;
               if (cnt_q == BEAT_LAST) begin
                  done_d = 1'b1;
                  state_d = CPU_IDLE;
               end
            end
         end
         default: state_d = CPU_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= CPU_IDLE;
         req_q <= 1'b0;
         addr_q <= '0;
         cnt_q <= 2'h0;
         done_q <= 1'b0;
         wv_q <= 1'b0;
         word_q <= '0;
         idx_q <= 2'h0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         addr_q <= addr_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         wv_q <= wv_d;
         word_q <= word_d;
         idx_q <= idx_d;
      end
   end

   assign bus.cache_burst_request = req_q;
   assign bus.cpu_addr = addr_q;
   assign o_word_valid = wv_q;
   assign o_word = word_q;
   assign o_word_index = idx_q;
   assign o_fill_done = done_q;
endmodule // burst_fill_cpu_end
`default_nettype wire

//--- tb/burst_fill_sva.sv
// Checker for the link between the processor end and the sequencer.
`timescale 1ns/100ps
`default_nettype none
module burst_fill_sva
   import burst_fill_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Link signals
   input wire logic cache_burst_request,
   input wire logic cache_burst_acknowledge,
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic data_valid,
   input wire logic [DATA_W-1:0] data
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   a_ack_needs_req: assert property (
      $rose(cache_burst_acknowledge) |-> cache_burst_request) else $error("ack without request");
   a_ack_one_cycle: assert property (
      cache_burst_acknowledge |=> !cache_burst_acknowledge) else $error("ack longer than one cycle");
   a_beat_pattern: assert property (
      cache_burst_acknowledge |-> ##2 data_valid[*4] ##1 !data_valid) else $error("beats not 3-1-1-1");
   a_valid_after_ack: assert property (
      $rose(data_valid) |-> $past(cache_burst_acknowledge, 2)) else $error("word without burst");
   a_req_held: assert property (
      cache_burst_request && !cache_burst_acknowledge |=> cache_burst_request) else $error("request dropped");
   a_addr_stable: assert property (
      cache_burst_acknowledge |=> $stable(cpu_addr)[*5]) else $error("start address moved in burst");
   a_no_early_req: assert property (
      cache_burst_acknowledge |=> !cache_burst_request[*5]) else $error("request before fourth word");
   a_req_release: assert property (
      $fell(cache_burst_request) |-> $past(cache_burst_acknowledge)) else $error("request released early");
endmodule // burst_fill_sva
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench joining the processor end to the sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import burst_fill_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_fill_req = 1'b0;
   logic [ADDR_W-1:0] i_fill_addr = '0;
   logic i_write_en = 1'b0;
   logic [ADDR_W-1:0] i_write_addr = '0;
   logic [DATA_W-1:0] i_write_data = '0;
   logic o_busy;
   logic o_word_valid;
   logic o_fill_done;
   logic [DATA_W-1:0] o_word;
   logic [1:0] o_word_index;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   int fails = 0;
   int cmp_count = 0;
   always #2 i_sys_clk = ~i_sys_clk;
   burst_fill_if bus ();
   burst_fill_address_sequencer i_burst_fill_address_sequencer (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .bus(bus), .i_write_en(i_write_en), .i_write_addr(i_write_addr), .i_write_data(i_write_data),
      .o_busy(o_busy));
   burst_fill_cpu_end i_burst_fill_cpu_end (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .bus(bus),
      .i_fill_req(i_fill_req), .i_fill_addr(i_fill_addr), .o_word_valid(o_word_valid), .o_word(o_word),
      .o_word_index(o_word_index), .o_fill_done(o_fill_done));
   burst_fill_sva i_burst_fill_sva (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .cache_burst_request(bus.cache_burst_request), .cache_burst_acknowledge(bus.cache_burst_acknowledge),
      .cpu_addr(bus.cpu_addr), .data_valid(bus.data_valid), .data(bus.data));
   function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] a, input int k);
      return {a[ADDR_W-1:LOW_W], LOW_W'(a[1:0] + k)};
   endfunction
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // The RAM is not reset, so every block is written before it is read.
   task automatic wr(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] d;
      d = $urandom;
      @(negedge i_sys_clk);
      i_write_en = 1'b1;
      i_write_addr = a;
      i_write_data = d;
      mem[a] = d;
      @(negedge i_sys_clk);
      i_write_en = 1'b0;
   endtask
   task automatic fill(input logic [ADDR_W-1:0] a, input bit clash);
      int k;
      k = 0;
      @(negedge i_sys_clk);
      chk(32'(o_busy), 32'h0);
      i_fill_req = 1'b1;
      i_fill_addr = a;
      // A write in the same cycle must hold the burst off without losing it.
      if (clash) begin
         i_write_en = 1'b1;
         i_write_addr = beat_addr(a, 0);
         i_write_data = $urandom;
         mem[beat_addr(a, 0)] = i_write_data;
      end
      @(negedge i_sys_clk);
      i_fill_req = 1'b0;
      i_write_en = 1'b0;
      for (int n = 0; n < 40 && k < BURST_WORDS; n++) begin
         @(negedge i_sys_clk);
         if (o_word_valid === 1'b1) begin
            chk(o_word, mem[beat_addr(a, k)]);
            chk(32'(o_word_index), 32'(k));
            chk(32'(o_fill_done), 32'(k == BURST_WORDS - 1));
            if (k == 0) begin
               chk(32'(o_busy), 32'h1);
            end
            k++;
         end
      end
      if (k != BURST_WORDS) begin
         fails++;
         conclude();
      end
      chk(32'(o_busy), 32'h0);
   endtask
   initial begin
      logic [ADDR_W-1:0] base;
      void'($urandom(14974));
      repeat (12) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_sys_rst = 1'b0;
      for (int i = 0; i < 12; i++) begin
         base = ADDR_W'($urandom);
         if (i == 11) begin
            base = '1;
         end
         for (int w = 0; w < BURST_WORDS; w++) begin
            wr(beat_addr(base, w));
         end
         // Every start word is used, so the low counter has to wrap.
         base[1:0] = 2'(i);
         fill(base, i % 4 == 1);
      end
      conclude();
   end
endmodule // tb
`default_nettype wire
